// ===== ref_ladder_regs.svh
/*
  Register offsets, field positions, reset values and scaling constants of the
  comparator reference ladder control block.
  Assumes inclusion by bare name from the package and the design modules.
*/
// How it works
// - Bit 7 powers the reference ladder when set, powers it down when clear.
// - Bit 6 routes the reference level onto its shared port pin when set.
// - While bit 6 is set, the pin's direction bit 5 is overridden.
// - Bit 5 picks low range (steps of span/24) or high range (quarter plus span/32).
// - Bit 4 picks the supply span: external reference pins or device supply.
// - Bits 3 to 0 give an unsigned tap level from 0 to 15.
// - Level is tap/24 of span in low range, span/4 plus tap/32 in high range.
// - Any reset clears power, pin drive, range and tap bits.
// - Waking from sleep leaves every control bit unchanged.
// - The reference works from its own control register, whatever the comparators do.
// - All eight control bits are readable, writable, and reset to zero.
`ifndef REF_LADDER_REGS_SVH
`define REF_LADDER_REGS_SVH

// Register byte addresses
`define ADDR_LADDER_CONTROL 12'h000
`define ADDR_LADDER_STATUS 12'h004
`define ADDR_PIN_DIRECTION 12'h008
`define ADDR_MSB 11
`define WORD_LSB 2

// Control field positions
`define BIT_POWER_ON 7
`define BIT_PIN_DRIVE 6
`define BIT_RANGE 5
`define BIT_SOURCE 4
`define TAP_MSB 3
`define TAP_LSB 0
`define PIN_DIR_BIT 5

// Reset values
`define CONTROL_RESET 8'h00
`define PIN_DIR_RESET 8'hFE

// Level scaling, level expressed in 1/96ths of the span
`define LEVEL_DENOM 8'h60
`define LOW_STEP 8'h04
`define HIGH_BASE 8'h18
`define HIGH_STEP 8'h03

// AHB encodings
`define HTRANS_NONSEQ 2'b10
`define HTRANS_SEQ 2'b11
`define HSIZE_WORD 3'b010

`endif

// ===== ref_ladder_pkg.sv
/*
  Types shared by the reference ladder control modules.
  Assumes the constants header is present beside it.
*/
package ref_ladder_pkg;
  `include "ref_ladder_regs.svh"

  // Bus slave states
  typedef enum logic [2:0]
  {
    st_idle = 3'b001,
    st_write = 3'b010,
    st_read = 3'b100
  } bus_state_e;

  // Decoded register selection
  typedef enum logic [1:0]
  {
    sel_control = 2'b00,
    sel_status = 2'b01,
    sel_pindir = 2'b10,
    sel_none = 2'b11
  } reg_sel_e;

  typedef logic [7:0] level_t;
endpackage

// ===== ref_level_model.sv
/*
  Combinational model of the selected reference level in 1/96ths of the span.
  Assumes its inputs come from the next value of the control register.
*/
`timescale 1ns/10ps
`include "ref_ladder_regs.svh"
module ref_level_model
  import ref_ladder_pkg::*;
(
  // Settings
  input wire logic range_select,
  input wire logic [3:0] tap_level,
  // Level in 96ths of the span
  output level_t level_96
);
  // Common denominator 96 keeps both ranges exact in integers
  always_comb
  begin
    if (range_select)
      level_96 = level_t'({4'h0, tap_level}) * `LOW_STEP;
    else
      level_96 = `HIGH_BASE + level_t'({4'h0, tap_level}) * `HIGH_STEP;
  end
endmodule

// ===== ahb_addr_decode.sv
/*
  Address decoder for the ladder register window.
  Assumes word-aligned accesses on a 12-bit local offset.
*/
`timescale 1ns/10ps
`include "ref_ladder_regs.svh"
module ahb_addr_decode
  import ref_ladder_pkg::*;
(
  // Local address
  input wire logic [11:0] offset,
  // Decoded selection
  output reg_sel_e sel
);
  // Unknown offsets read zero and drop writes
  always_comb
  begin
    case (offset)
      `ADDR_LADDER_CONTROL: sel = sel_control;
      `ADDR_LADDER_STATUS: sel = sel_status;
      `ADDR_PIN_DIRECTION: sel = sel_pindir;
      default: sel = sel_none;
    endcase
  end
endmodule

// ===== ref_ladder_ctrl.sv
/*
  Comparator reference ladder control: AHB-Lite slave holding the 8-bit
  ladder control register and a port direction register, driving the analog
  ladder settings and the shared pin control, plus a digital level model.
  Assumes a single 40 MHz clock and synchronous inputs; sleep is only a
  level input that must not disturb any setting.
*/
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "ref_ladder_regs.svh"
module ref_ladder_ctrl
  import ref_ladder_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Power state
  input wire logic sleep_active,
  // Analog ladder controls
  output logic ref_power_on,
  output logic ref_pin_drive,
  output logic range_select,
  output logic supply_source_select,
  output logic [3:0] tap_level,
  // Shared pin controls
  output logic pin_direction_bit5,
  output logic pin_analog_select,
  // Modeled level in 96ths of the span
  output level_t reference_level_output
);
  typedef struct packed
  {
    bus_state_e state;
    logic [11:0] offset;
    logic [7:0] control;
    logic [7:0] pin_dir;
    logic [31:0] rdata;
    logic pin_dir5;
    logic pin_analog;
    level_t level;
  } state_s;

  state_s cur;
  state_s next_cur;
  reg_sel_e addr_sel;
  reg_sel_e data_sel;
  level_t model_level;
  logic take;
  logic [7:0] next_control;
  logic [7:0] next_pin_dir;

  // Byte-wide register image placed in the low lane
  function automatic logic [31:0] widen(input logic [7:0] v);
    widen = {24'h0000_00, v};
  endfunction

  // Address-phase decode for reads, held-offset decode for writes
  ahb_addr_decode u_addr_dec
  (
    .offset({haddr[`ADDR_MSB:`WORD_LSB], 2'b00}),
    .sel(addr_sel)
  );

  ahb_addr_decode u_data_dec
  (
    .offset(cur.offset),
    .sel(data_sel)
  );

  // Register writes resolved on their own, so the level model sees the new
  // settings without a path looping back through next_cur
  always_comb
  begin
    next_control = cur.control;
    next_pin_dir = cur.pin_dir;
    // Write data phase commits the register; sleep plays no part
    if (cur.state == st_write)
    begin
      case (data_sel)
        sel_control: next_control = hwdata[7:0];
        sel_pindir: next_pin_dir = hwdata[7:0];
        default: next_control = cur.control;
      endcase
    end
  end

  // Level follows the settings being committed this cycle
  ref_level_model u_level
  (
    .range_select(next_control[`BIT_RANGE]),
    .tap_level(next_control[`TAP_MSB:`TAP_LSB]),
    .level_96(model_level)
  );

  // Valid transfer taken in the address phase
  assign take = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);

  // Next-state logic for the whole block
  always_comb
  begin
    next_cur = cur;
    next_cur.rdata = 32'h0000_0000;
    // Settings committed by a write data phase, if any
    next_cur.control = next_control;
    next_cur.pin_dir = next_pin_dir;
    // New address phase
    if (take)
    begin
      next_cur.offset = {haddr[`ADDR_MSB:`WORD_LSB], 2'b00};
      if (hwrite)
        next_cur.state = st_write;
      else
      begin
        next_cur.state = st_read;
        case (addr_sel)
          sel_control: next_cur.rdata = widen(next_cur.control);
          sel_status: next_cur.rdata = widen(model_level);
          sel_pindir: next_cur.rdata = widen(next_cur.pin_dir);
          default: next_cur.rdata = 32'h0000_0000;
        endcase
      end
    end
    else
    begin
      next_cur.state = st_idle;
    end
    // Pin drive forces the shared pin away from the digital buffer
    if (next_cur.control[`BIT_PIN_DRIVE])
    begin
      next_cur.pin_dir5 = 1'b1;
      next_cur.pin_analog = 1'b1;
    end
    else
    begin
      next_cur.pin_dir5 = next_cur.pin_dir[`PIN_DIR_BIT];
      next_cur.pin_analog = 1'b0;
    end
    next_cur.level = model_level;
    // Unused state codes fall back to idle
    case (next_cur.state)
      st_idle, st_write, st_read: next_cur.state = next_cur.state;
      default: next_cur.state = st_idle;
    endcase
  end

  // State register; reset clears every control bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cur.state <= st_idle;
      cur.offset <= 12'h000;
      cur.control <= `CONTROL_RESET;
      cur.pin_dir <= `PIN_DIR_RESET;
      cur.rdata <= 32'h0000_0000;
      cur.pin_dir5 <= 1'b1;
      cur.pin_analog <= 1'b0;
      cur.level <= `HIGH_BASE;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Outputs straight from flip-flops, no extra latency
  assign ref_power_on = cur.control[`BIT_POWER_ON];
  assign ref_pin_drive = cur.control[`BIT_PIN_DRIVE];
  assign range_select = cur.control[`BIT_RANGE];
  assign supply_source_select = cur.control[`BIT_SOURCE];
  assign tap_level = cur.control[`TAP_MSB:`TAP_LSB];
  assign pin_direction_bit5 = cur.pin_dir5;
  assign pin_analog_select = cur.pin_analog;
  assign reference_level_output = cur.level;
  assign hrdata = cur.rdata;
  assign hreadyout = 1'b1; // Zero wait states
  assign hresp = 1'b0; // Always OKAY

  // Sleep is observed but deliberately has no effect on settings
  logic unused_sleep;
  assign unused_sleep = sleep_active ^ (hsize == `HSIZE_WORD) ^ (|haddr[31:12])
    ^ (|haddr[1:0]) ^ (|hwdata[31:8]);
endmodule

// ===== ref_ladder_ctrl_assertions.sv
/* Checker for the reference ladder control block.
   Assumes binding to ref_ladder_ctrl with hready looped from hreadyout. */
`timescale 1ns/10ps
module ref_ladder_ctrl_assertions
  import ref_ladder_pkg::*;
(
  // Bus side
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Ladder side
  input wire logic ref_power_on,
  input wire logic ref_pin_drive,
  input wire logic range_select,
  input wire logic supply_source_select,
  input wire logic [3:0] tap_level,
  input wire logic pin_direction_bit5,
  input wire logic pin_analog_select,
  input wire level_t reference_level_output
);
  // Control byte and a taken transfer to the control word
  logic [7:0] ctl;
  logic taken;
  assign ctl = {ref_power_on, ref_pin_drive, range_select, supply_source_select, tap_level};
  assign taken = hsel && hready && htrans[1] && haddr[11:2] == 10'h000;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Write lands one edge after its data phase
  sequence ctl_wr;
    taken && hwrite ##1 1'b1;
  endsequence
  chk_write_lands: assert property (ctl_wr |=> ctl == $past(hwdata[7:0]))
    else $error("control outputs differ from written byte");
  chk_hold_idle: assert property (!(taken && hwrite) |-> ##2 $stable(ctl))
    else $error("control outputs moved without a write");
  chk_pin_override: assert property (ref_pin_drive |-> pin_direction_bit5)
    else $error("pin direction not overridden");
  chk_pin_route: assert property (pin_analog_select == ref_pin_drive)
    else $error("pin routing differs from pin drive bit");
  chk_low_level: assert property (range_select |-> reference_level_output == {2'b00, tap_level, 2'b00})
    else $error("low range level wrong");
  chk_high_level: assert property (!range_select |->
    reference_level_output == 8'h18 + {4'h0, tap_level} * 8'h03)
    else $error("high range level wrong");
  chk_read_back: assert property (taken && !hwrite |=> hrdata == {24'h00_0000, ctl})
    else $error("control read data wrong");
  chk_unmapped_zero: assert property (hsel && hready && htrans[1] && !hwrite &&
    haddr[11:2] > 10'h002 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule

bind ref_ladder_ctrl ref_ladder_ctrl_assertions ref_ladder_ctrl_assertions_i (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .ref_power_on(ref_power_on),
  .ref_pin_drive(ref_pin_drive), .range_select(range_select),
  .supply_source_select(supply_source_select), .tap_level(tap_level),
  .pin_direction_bit5(pin_direction_bit5), .pin_analog_select(pin_analog_select),
  .reference_level_output(reference_level_output));

// ===== tb.sv
/* Self-checking bench for the reference ladder control block.
   Acts as the only AHB-Lite master; hready is looped from hreadyout. */
`timescale 1ns/10ps
module tb;
  import ref_ladder_pkg::*;
  logic hclk, hresetn, hsel, hwrite, sleep_active, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] tap_level;
  logic ref_power_on, ref_pin_drive, range_select, supply_source_select;
  logic pin_direction_bit5, pin_analog_select;
  level_t reference_level_output;
  int n_errors, comparisons;
  ref_ladder_ctrl ref_ladder_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sleep_active(sleep_active), .ref_power_on(ref_power_on), .ref_pin_drive(ref_pin_drive),
    .range_select(range_select), .supply_source_select(supply_source_select),
    .tap_level(tap_level), .pin_direction_bit5(pin_direction_bit5),
    .pin_analog_select(pin_analog_select), .reference_level_output(reference_level_output));
  // Verdict and end of run
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] outs();
    return {24'h00_0000, ref_power_on, ref_pin_drive, range_select, supply_source_select, tap_level};
  endfunction
  // Bounded wait for hready, so a stuck slave still ends the run
  task wt;
    for (int n = 0; n < 64; n++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        return;
    end
    n_errors++;
    summarize();
  endtask
  // One single word transfer; read data taken at the data phase edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    wt();
    htrans <= 2'b00;
    hwdata <= d;
    wt();
    rd = hrdata;
    chk(hresp, 0);
  endtask
  task t_bits;
    @(negedge hclk);
    chk(outs(), 0);
    chk({pin_direction_bit5, reference_level_output}, 9'h118);
    xfer(0, 12'h008, 0);
    chk(rd, 32'h0000_00FE);
    for (int i = 0; i < 8; i++)
    begin
      xfer(1, 12'h000, 32'hFFFF_FF00 | (32'h0000_0001 << i));
      @(negedge hclk);
      chk(outs(), 32'h0000_0001 << i);
      xfer(0, 12'h000, 0);
      chk(rd, 32'h0000_0001 << i);
    end
    $display("bits test done");
  endtask
  // Every tap in both ranges, level in 96ths of the span
  task t_levels;
    for (int r = 0; r < 2; r++)
      for (int t = 0; t < 16; t++)
      begin
        xfer(1, 12'h000, 32'(r * 32 + t));
        @(negedge hclk);
        chk(reference_level_output, r ? t * 4 : 24 + t * 3);
        xfer(0, 12'h004, 0);
        chk(rd, r ? t * 4 : 24 + t * 3);
      end
    $display("levels test done");
  endtask
  task t_pin;
    xfer(1, 12'h008, 0);
    xfer(1, 12'h000, 0);
    @(negedge hclk);
    chk({pin_direction_bit5, pin_analog_select}, 2'b00);
    xfer(0, 12'h008, 0);
    chk(rd, 0);
    xfer(1, 12'h000, 32'h0000_0040);
    @(negedge hclk);
    chk({pin_direction_bit5, pin_analog_select}, 2'b11);
    $display("pin test done");
  endtask
  // Sleep keeps settings; unmapped word; reset in mid-run clears
  task t_sleep;
    xfer(1, 12'h000, 32'h0000_00F7);
    sleep_active <= 1'b1;
    repeat (5) @(posedge hclk);
    sleep_active <= 1'b0;
    xfer(0, 12'h000, 0);
    chk(rd, 32'h0000_00F7);
    xfer(0, 12'h00C, 0);
    chk(rd, 0);
    hresetn <= 1'b0;
    @(negedge hclk);
    chk(outs(), 0);
    @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1, 12'h000, 32'h0000_0081);
    @(negedge hclk);
    chk(outs(), 32'h0000_0081);
    chk(pin_direction_bit5, 1);
    $display("sleep test done");
  endtask
  // 40 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Main sequence
  initial
  begin
    {hresetn, hsel, hwrite, sleep_active, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_bits();
    t_levels();
    t_pin();
    t_sleep();
    summarize();
  end
endmodule
